// file: dcee_debug_cmd_check.sv
// Debug command checker, register/CSR write executor and mass-erase sequencer.
// How it works
// - Status bit 1 flags an illegal access; writing 1 clears it.
// - Access to unimplemented memory or a flash write sets the access flag.
// - A register access with an invalid register number sets the access flag.
// - An illegal access returns 0xEE for each data byte.
// - Status bit 0 flags an illegal command; writing 1 clears it.
// - An unimplemented opcode sets the command flag.
// - Block read, fill or repeat read out of sequence sets the command flag.
// - A halt-only command outside the halt state sets the command flag.
// - Restricted commands while disabled, erasing or secured set the command flag.
// - An illegal read command returns 0xEE for every data byte.
// - In halt state, register write stores the 32-bit operand into the register.
// - With handshake enabled, pulse after the register write completes.
// - Outside halt state the register write is rejected and flagged.
// - Opcode 0x0D plus two bytes, high first, writes the status register anytime.
// - Status write gives no handshake, updates control bits, clears flags written 1.
// - Two erase commands in succession set erase-pending and request mass erase.
// - Any other command after one erase command restarts the erase sequence.
// - 512 serial clocks between erase commands force a soft reset and restart.
// - Erase-pending clears when the erase finishes; erase gives no handshake.
`default_nettype none

module dcee_debug_cmd_check
  import dcee_pkg::*;
#(
  parameter logic [7:0] ERASE_OP = 8'h0E,
  parameter logic [7:0] WRITE_REG_OP = 8'h48,
  parameter logic [7:0] READ_MEM_OP = 8'h30,
  parameter logic [7:0] BLOCK_READ_OP = 8'h32,
  parameter logic [7:0] REPEAT_READ_OP = 8'h34,
  parameter logic [7:0] WRITE_MEM_OP = 8'h10,
  parameter logic [7:0] BLOCK_FILL_OP = 8'h12,
  parameter logic [7:0] FAMILY_MASK = 8'hFE,
  parameter int unsigned REG_NUM_W = 4,
  parameter int unsigned NUM_CPU_REGS = 10,
  parameter logic [255:0] IMPL_MASK = {128'h0, 128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFFF},
  parameter logic [255:0] HALT_MASK = {128'h0, 128'hFFFFFFFF_FFFFFFFF_00000000_00000000},
  parameter logic [255:0] ALWAYS_MASK = {128'h0, 128'h00000000_00000000_00000000_0000FFFF}
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [31:0] cmdData,
  input wire logic [REG_NUM_W-1:0] cmdRegNum,
  input wire logic debugHaltActive,
  input wire logic debugEnabled,
  input wire logic deviceSecured,
  input wire logic ackEnable,
  input wire logic accessCheck,
  input wire logic accessUnimpl,
  input wire logic accessFlashWrite,
  input wire logic cpuRegWrDone,
  input wire logic eraseDone,
  input wire logic debugSerialClock,
  output logic illegalAccessFlag,
  output logic illegalCommandFlag,
  output logic erasePending,
  output logic [CSR_CTRL_W-1:0] csrControl,
  output logic returnEeFill,
  output logic [7:0] fillByte,
  output logic cpuRegWrEn,
  output logic [REG_NUM_W-1:0] cpuRegWrNum,
  output logic [31:0] cpuRegWrData,
  output logic ackPulse,
  output logic massEraseReq,
  output logic softResetReq
);

  logic serSync1_reg, serSync2_reg, serSync3_reg, serEdge;
  logic isErase, isCsrWr, isWrReg, isBread, isFill, isSame, isRead, isWrite;
  logic seqBad, alwaysOk, illegalCmd, legalCmd, badRegNum, accIllegal, csrWr, timeout;
  dcee_erase_e eraseState_reg;
  dcee_kind_e lastKind_reg;
  logic [TIMEOUT_CNT_W-1:0] tCount_reg;
  logic wrBusy_reg;

  function automatic logic inFamily(input logic [7:0] op, input logic [7:0] base);
    inFamily = (op & FAMILY_MASK) == (base & FAMILY_MASK);
  endfunction : inFamily

  // The serial clock is foreign to this domain; only its synchronised copy is read.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serSync1_reg <= 1'b0;
      serSync2_reg <= 1'b0;
      serSync3_reg <= 1'b0;
    end else begin
      serSync1_reg <= debugSerialClock;
      serSync2_reg <= serSync1_reg;
      serSync3_reg <= serSync2_reg;
    end
  end
  assign serEdge = serSync2_reg & ~serSync3_reg;

  always_comb begin
    isErase = cmdOpcode == ERASE_OP;
    isCsrWr = cmdOpcode == WRITE_CSR_OP;
    isWrReg = cmdOpcode == WRITE_REG_OP;
    isBread = inFamily(cmdOpcode, BLOCK_READ_OP);
    isFill = inFamily(cmdOpcode, BLOCK_FILL_OP);
    isSame = inFamily(cmdOpcode, REPEAT_READ_OP);
    isRead = inFamily(cmdOpcode, READ_MEM_OP);
    isWrite = inFamily(cmdOpcode, WRITE_MEM_OP);
    seqBad = (isBread && !(lastKind_reg == LK_READ || lastKind_reg == LK_BREAD))
          || (isFill && !(lastKind_reg == LK_WRITE || lastKind_reg == LK_FILL))
          || (isSame && !(lastKind_reg == LK_READ || lastKind_reg == LK_SAME));
    alwaysOk = ALWAYS_MASK[cmdOpcode] || isCsrWr || isErase;
    illegalCmd = cmdValid && (!(IMPL_MASK[cmdOpcode] || isCsrWr || isErase)
      || seqBad
      || ((HALT_MASK[cmdOpcode] || isWrReg) && !debugHaltActive)
      || (!alwaysOk && (!debugEnabled || erasePending || deviceSecured)));
    legalCmd = cmdValid && !illegalCmd;
    badRegNum = legalCmd && isWrReg && (32'(cmdRegNum) >= NUM_CPU_REGS);
    accIllegal = accessCheck && (accessUnimpl || accessFlashWrite);
    csrWr = legalCmd && isCsrWr;
    timeout = eraseState_reg == ER_ARMED && serEdge && tCount_reg == TIMEOUT_LAST;
  end

  // Set wins over a write-one clear arriving in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      illegalAccessFlag <= 1'b0;
      illegalCommandFlag <= 1'b0;
    end else begin
      illegalAccessFlag <= badRegNum || accIllegal
        || (illegalAccessFlag && !(csrWr && cmdData[CSR_ILL_ACC_BIT]));
      illegalCommandFlag <= illegalCmd
        || (illegalCommandFlag && !(csrWr && cmdData[CSR_ILL_CMD_BIT]));
    end
  end

  // Replacement bytes hold until the next command is taken.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      returnEeFill <= 1'b0;
      fillByte <= ILLEGAL_FILL_BYTE;
    end else begin
      fillByte <= ILLEGAL_FILL_BYTE;
      if (cmdValid) begin
        returnEeFill <= illegalCmd || badRegNum;
      end else if (accIllegal) begin
        returnEeFill <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      csrControl <= CSR_CTRL_RESET;
    end else if (csrWr) begin
      csrControl <= cmdData[CSR_CTRL_LSB +: CSR_CTRL_W];
    end
  end

  // Sequence history moves only on legal commands, so an illegal one leaves it intact.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lastKind_reg <= LK_OTHER;
    end else if (legalCmd) begin
      if (isRead) begin
        lastKind_reg <= LK_READ;
      end else if (isBread) begin
        lastKind_reg <= LK_BREAD;
      end else if (isWrite) begin
        lastKind_reg <= LK_WRITE;
      end else if (isFill) begin
        lastKind_reg <= LK_FILL;
      end else if (isSame) begin
        lastKind_reg <= LK_SAME;
      end else begin
        lastKind_reg <= LK_OTHER;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpuRegWrEn <= 1'b0;
      cpuRegWrNum <= '0;
      cpuRegWrData <= '0;
      wrBusy_reg <= 1'b0;
      ackPulse <= 1'b0;
    end else begin
      cpuRegWrEn <= legalCmd && isWrReg && !badRegNum;
      if (legalCmd && isWrReg && !badRegNum) begin
        cpuRegWrNum <= cmdRegNum;
        cpuRegWrData <= cmdData;
      end
      if (cpuRegWrEn) begin
        wrBusy_reg <= 1'b1;
      end else if (cpuRegWrDone) begin
        wrBusy_reg <= 1'b0;
      end
      ackPulse <= wrBusy_reg && cpuRegWrDone && ackEnable;
    end
  end

  // Erase pairing: the first erase arms, the second requests; anything else disarms.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      eraseState_reg <= ER_IDLE;
      tCount_reg <= TIMEOUT_CNT_RESET;
      massEraseReq <= 1'b0;
      softResetReq <= 1'b0;
    end else begin
      massEraseReq <= 1'b0;
      softResetReq <= timeout;
      if (serEdge && eraseState_reg == ER_ARMED) begin
        tCount_reg <= tCount_reg + 1'b1;
      end
      if (cmdValid && !isErase) begin
        eraseState_reg <= ER_IDLE;
      end else if (legalCmd && isErase) begin
        tCount_reg <= TIMEOUT_CNT_RESET;
        if (eraseState_reg == ER_ARMED) begin
          eraseState_reg <= ER_IDLE;
          massEraseReq <= 1'b1;
        end else begin
          eraseState_reg <= ER_ARMED;
        end
      end else if (timeout) begin
        eraseState_reg <= ER_IDLE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      erasePending <= 1'b0;
    end else begin
      erasePending <= (eraseState_reg == ER_ARMED && legalCmd && isErase)
        || (erasePending && !eraseDone);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_first_erase;
    eraseState_reg == ER_IDLE && legalCmd && isErase;
  endsequence
  sequence s_second_erase;
    eraseState_reg == ER_ARMED && legalCmd && isErase;
  endsequence

  property p_unimpl_flag;
    cmdValid && !IMPL_MASK[cmdOpcode] && !isCsrWr && !isErase
      |=> illegalCommandFlag && returnEeFill;
  endproperty
  a_unimpl_flag: assert property (p_unimpl_flag) else $error("opcode not flagged");

  property p_wrreg_reject;
    cmdValid && isWrReg && !debugHaltActive |=> illegalCommandFlag && !cpuRegWrEn;
  endproperty
  a_wrreg_reject: assert property (p_wrreg_reject) else $error("write outside halt");

  property p_wrreg_do;
    legalCmd && isWrReg && !badRegNum |=> cpuRegWrEn && cpuRegWrData == $past(cmdData);
  endproperty
  a_wrreg_do: assert property (p_wrreg_do) else $error("register write not issued");

  property p_cmd_clear;
    csrWr && cmdData[CSR_ILL_CMD_BIT] |=> !illegalCommandFlag;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command flag not cleared");

  property p_acc_set;
    accIllegal || badRegNum |=> illegalAccessFlag ##1 (illegalAccessFlag || $past(csrWr));
  endproperty
  a_acc_set: assert property (p_acc_set) else $error("illegal access not flagged");

  property p_erase_pair;
    s_first_erase ##1 (!cmdValid && !timeout) ##1 s_second_erase
      |=> massEraseReq && erasePending ##1 !massEraseReq;
  endproperty
  a_erase_pair: assert property (p_erase_pair) else $error("erase pair did not request");

  property p_erase_break;
    s_first_erase ##[1:2] (cmdValid && !isErase) |=> eraseState_reg == ER_IDLE && !massEraseReq;
  endproperty
  a_erase_break: assert property (p_erase_break) else $error("erase not restarted");

  property p_timeout;
    timeout |=> softResetReq && eraseState_reg == ER_IDLE ##1 !softResetReq;
  endproperty
  a_timeout: assert property (p_timeout) else $error("erase timeout missing");

  property p_ack;
    wrBusy_reg && cpuRegWrDone && ackEnable |=> ackPulse ##1 !ackPulse;
  endproperty
  a_ack: assert property (p_ack) else $error("handshake pulse missing");

  property p_csr_no_ack;
    csrWr && !wrBusy_reg |=> !ackPulse;
  endproperty
  a_csr_no_ack: assert property (p_csr_no_ack) else $error("status write pulsed");

endmodule : dcee_debug_cmd_check

`default_nettype wire

// file: dcee_host_model.sv
// Behavioural debug host that issues decoded commands and runs the serial clock.
`default_nettype none

module dcee_host_model
  import dcee_pkg::*;
#(
  parameter logic [7:0] ERASE_OP = 8'h0E
) (
  input wire logic clock,
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [31:0] cmdData,
  output logic [3:0] cmdRegNum,
  output logic debugSerialClock
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    cmdData = 32'h00000000;
    cmdRegNum = 4'h0;
    debugSerialClock = 1'b0;
  end

  // Released lines flip so that a stale operand can never pass for a fresh one.
  task automatic send(input logic [7:0] op, input logic [31:0] data, input logic [3:0] num);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOpcode <= op;
    cmdData <= data;
    cmdRegNum <= num;
    @(posedge clock);
    cmdValid <= 1'b0;
    cmdOpcode <= ~op;
    cmdData <= ~data;
    cmdRegNum <= ~num;
  endtask : send

  task automatic writeCsr(input logic [7:0] hi, input logic [7:0] lo);
    send(WRITE_CSR_OP, {16'h0000, hi, lo}, 4'h0);
  endtask : writeCsr

  task automatic eraseTwice;
    send(ERASE_OP, 32'h00000000, 4'h0);
    send(ERASE_OP, 32'h00000000, 4'h0);
  endtask : eraseTwice

  task automatic serialTicks(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      debugSerialClock <= 1'b1;
      repeat (4) @(posedge clock);
      debugSerialClock <= 1'b0;
    end
  endtask : serialTicks
endmodule : dcee_host_model

`default_nettype wire

// file: dcee_pkg.sv
// Constants shared by the debug command checker and mass-erase sequencer.
`default_nettype none

package dcee_pkg;

  // Status/control register field positions.
  localparam int unsigned CSR_WIDTH = 16;
  localparam int unsigned CSR_ILL_CMD_BIT = 0;
  localparam int unsigned CSR_ILL_ACC_BIT = 1;
  localparam int unsigned CSR_ERASE_BIT = 7;
  localparam int unsigned CSR_CTRL_LSB = 8;
  localparam int unsigned CSR_CTRL_W = 8;

  // Values after reset.
  localparam logic [CSR_CTRL_W-1:0] CSR_CTRL_RESET = 8'h00;
  localparam logic [7:0] OPCODE_RESET = 8'h00;

  // Opcode of the status/control write command.
  localparam logic [7:0] WRITE_CSR_OP = 8'h0D;

  // Byte returned in place of data on an illegal command or access.
  localparam logic [7:0] ILLEGAL_FILL_BYTE = 8'hEE;

  // Debug serial clock cycles allowed between the two erase commands.
  localparam int unsigned ERASE_TIMEOUT_CYCLES = 512;
  localparam int unsigned TIMEOUT_CNT_W = 10;
  localparam logic [TIMEOUT_CNT_W-1:0] TIMEOUT_CNT_RESET = 10'h000;
  localparam logic [TIMEOUT_CNT_W-1:0] TIMEOUT_LAST =
    TIMEOUT_CNT_W'(ERASE_TIMEOUT_CYCLES - 1);

  typedef enum logic [0:0] {ER_IDLE, ER_ARMED} dcee_erase_e;

  typedef enum logic [2:0] {LK_OTHER, LK_READ, LK_WRITE, LK_BREAD, LK_FILL, LK_SAME} dcee_kind_e;

endpackage : dcee_pkg

`default_nettype wire

// file: tb_debug_command_error_and_erase.sv
// Self-checking bench for the debug command checker and erase sequencer.
`default_nettype none

module tb_debug_command_error_and_erase import dcee_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ER_OP = 8'h0E;
  localparam logic [7:0] WR_REG = 8'h48;
  localparam logic [7:0] RD_MEM = 8'h30;
  localparam logic [7:0] BLK_RD = 8'h32;
  logic clock, rst_n, halt, dbgEn, secured, ackEn, accUnimpl, accFlash, cmdValid, serClk;
  logic [2:0] strobe;
  logic [7:0] cmdOpcode, csrControl, fillByte;
  logic [31:0] cmdData, cpuRegWrData, lastData;
  logic [3:0] cmdRegNum, cpuRegWrNum, lastNum;
  logic illegal_access_flag, illegal_command_flag, erasePending, returnEeFill, cpuRegWrEn, ackPulse, eraseReq, softReq;
  int errCount, nChecks, nWr, nAck, nErase, nSoft;

  dcee_host_model #(.ERASE_OP(ER_OP)) u_dcee_host_model (.clock(clock), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdData(cmdData), .cmdRegNum(cmdRegNum), .debugSerialClock(serClk));

  dcee_debug_cmd_check #(.ERASE_OP(ER_OP), .WRITE_REG_OP(WR_REG), .READ_MEM_OP(RD_MEM),
    .BLOCK_READ_OP(BLK_RD)) u_dcee_debug_cmd_check (.clock(clock), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdData(cmdData), .cmdRegNum(cmdRegNum),
    .debugHaltActive(halt), .debugEnabled(dbgEn), .deviceSecured(secured), .ackEnable(ackEn),
    .accessCheck(strobe[2]), .accessUnimpl(accUnimpl), .accessFlashWrite(accFlash),
    .cpuRegWrDone(strobe[0]), .eraseDone(strobe[1]), .debugSerialClock(serClk),
    .illegalAccessFlag(illegal_access_flag), .illegalCommandFlag(illegal_command_flag), .erasePending(erasePending),
    .csrControl(csrControl), .returnEeFill(returnEeFill), .fillByte(fillByte),
    .cpuRegWrEn(cpuRegWrEn), .cpuRegWrNum(cpuRegWrNum), .cpuRegWrData(cpuRegWrData),
    .ackPulse(ackPulse), .massEraseReq(eraseReq), .softResetReq(softReq));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // One-cycle outputs are counted here so no scenario has to land on the exact cycle.
  always @(posedge clock) begin
    if (cpuRegWrEn === 1'b1) begin
      nWr <= nWr + 1;
      lastNum <= cpuRegWrNum;
      lastData <= cpuRegWrData;
    end
    if (ackPulse === 1'b1) nAck <= nAck + 1;
    if (eraseReq === 1'b1) nErase <= nErase + 1;
    if (softReq === 1'b1) nSoft <= nSoft + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic pulse(input int k);
    @(posedge clock);
    strobe[k] <= 1'b1;
    @(posedge clock);
    strobe[k] <= 1'b0;
    settle;
  endtask : pulse

  task automatic setMode(input logic h, input logic e, input logic s);
    @(posedge clock);
    halt <= h;
    dbgEn <= e;
    secured <= s;
    ackEn <= 1'b1;
  endtask : setMode

  task automatic t_reset;
    #1;
    chk({illegal_access_flag, illegal_command_flag, erasePending, returnEeFill}, 32'h0);
    chk({csrControl, fillByte}, 32'h00EE);
  endtask : t_reset

  task automatic t_reg_write;
    int w;
    int a;
    w = nWr;
    a = nAck;
    setMode(1'b0, 1'b1, 1'b0);
    u_dcee_host_model.send(WR_REG, 32'h12345678, 4'h1);
    settle;
    chk({illegal_command_flag, returnEeFill, fillByte}, 32'h3EE);
    chk(nWr, w);
    u_dcee_host_model.writeCsr(8'hA5, 8'h01);
    settle;
    chk({csrControl, illegal_command_flag}, 32'h14A);
    setMode(1'b1, 1'b1, 1'b0);
    u_dcee_host_model.send(WR_REG, 32'hCAFE0123, 4'h9);
    settle;
    chk(32'(lastNum), 32'h9);
    chk(lastData, 32'hCAFE0123);
    chk(nWr, w + 1);
    pulse(0);
    chk(nAck, a + 1);
    u_dcee_host_model.send(WR_REG, 32'h0BADF00D, 4'hA);
    settle;
    chk({illegal_access_flag, returnEeFill, 30'h0}, 32'hC0000000);
    chk(nWr, w + 1);
    u_dcee_host_model.writeCsr(8'hA5, 8'h02);
    settle;
    chk(32'(illegal_access_flag), 32'h0);
  endtask : t_reg_write

  task automatic t_access;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      accUnimpl <= (i == 0);
      accFlash <= (i == 1);
      pulse(2);
      chk({illegal_access_flag, returnEeFill, fillByte}, 32'h3EE);
      u_dcee_host_model.writeCsr(8'hA5, 8'h02);
      settle;
      chk(32'(illegal_access_flag), 32'h0);
    end
  endtask : t_access

  task automatic t_illegal_cmds;
    logic [7:0] ops [4] = '{8'h80, BLK_RD, RD_MEM, RD_MEM};
    logic [3:0] enM = 4'b1011;
    logic [3:0] secM = 4'b1000;
    for (int i = 0; i < 4; i++) begin
      setMode(1'b0, enM[i], secM[i]);
      u_dcee_host_model.send(ops[i], 32'h0, 4'h0);
      settle;
      chk({illegal_command_flag, returnEeFill}, 32'h3);
      u_dcee_host_model.writeCsr(8'hA5, 8'h01);
      settle;
      chk({csrControl, illegal_command_flag}, 32'h14A);
    end
    setMode(1'b0, 1'b1, 1'b0);
    u_dcee_host_model.send(RD_MEM, 32'h0, 4'h0);
    u_dcee_host_model.send(BLK_RD, 32'h0, 4'h0);
    settle;
    chk(32'(illegal_command_flag), 32'h0);
  endtask : t_illegal_cmds

  task automatic t_erase;
    int e;
    int a;
    e = nErase;
    a = nAck;
    u_dcee_host_model.eraseTwice();
    settle;
    chk({erasePending, 31'(nErase - e)}, 32'h80000001);
    u_dcee_host_model.send(RD_MEM, 32'h0, 4'h0);
    settle;
    chk(32'(illegal_command_flag), 32'h1);
    u_dcee_host_model.writeCsr(8'hA5, 8'h01);
    pulse(1);
    chk({erasePending, illegal_command_flag}, 32'h0);
    u_dcee_host_model.send(ER_OP, 32'h0, 4'h0);
    u_dcee_host_model.writeCsr(8'hA5, 8'h00);
    u_dcee_host_model.send(ER_OP, 32'h0, 4'h0);
    settle;
    chk(nErase, e + 1);
    u_dcee_host_model.send(ER_OP, 32'h0, 4'h0);
    settle;
    chk(nErase, e + 2);
    pulse(1);
    chk({erasePending, 31'(nAck - a)}, 32'h0);
  endtask : t_erase

  task automatic t_timeout;
    int s;
    int e;
    s = nSoft;
    e = nErase;
    u_dcee_host_model.send(ER_OP, 32'h0, 4'h0);
    u_dcee_host_model.serialTicks(511);
    repeat (8) @(posedge clock);
    chk(nSoft, s);
    u_dcee_host_model.serialTicks(1);
    repeat (8) @(posedge clock);
    chk(nSoft, s + 1);
    u_dcee_host_model.send(ER_OP, 32'h0, 4'h0);
    settle;
    chk(nErase, e);
  endtask : t_timeout

  task automatic wrapUp;
    $display("checks=%0d errors=%0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrapUp

  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    wrapUp();
  end

  initial begin
    {rst_n, halt, secured, ackEn, accUnimpl, accFlash, strobe} = '0;
    dbgEn = 1'b1;
    {errCount, nChecks, nWr, nAck, nErase, nSoft} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_reg_write();
    t_access();
    t_illegal_cmds();
    t_erase();
    t_timeout();
    wrapUp();
  end
endmodule : tb_debug_command_error_and_erase

`default_nettype wire
